// ---- verilog/lds_pkg.sv ----
// lds_pkg: constants and carrier types of the limit, display and system handler
// assumes one 10 MHz clock and a plain strobe register port with one-cycle read data
`default_nettype none
package lds_pkg;
  localparam int unsigned DW         = 32;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [3:0]  FIFO_FULL  = 4'h8;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_LIM_VOLT = 8'h00;
  localparam logic [7:0] OFS_LIM_CURR = 8'h04;
  localparam logic [7:0] OFS_LIM_FLO  = 8'h08;
  localparam logic [7:0] OFS_LIM_FHI  = 8'h0c;
  localparam logic [7:0] OFS_DISP     = 8'h10;
  localparam logic [7:0] OFS_ERR      = 8'h14;
  localparam logic [7:0] OFS_LOCK     = 8'h18;
  localparam logic [7:0] OFS_PON      = 8'h1c;
  localparam logic [7:0] OFS_FREQ     = 8'h20;
  localparam logic [7:0] OFS_CTRL     = 8'h24;
  localparam logic [7:0] OFS_STAT     = 8'h28;
  localparam logic [7:0] OFS_VLOW     = 8'h2c;

  // factory limit defaults: volts, tenths of amps, hertz
  localparam logic [15:0] VLIM_DFLT  = 16'h010e;
  localparam logic [15:0] CLIM_DFLT  = 16'h0064;
  localparam logic [15:0] FLO_DFLT   = 16'h002d;
  localparam logic [15:0] FHI_DFLT   = 16'h01f4;
  localparam logic [15:0] DUAL_ABOVE = 16'h00c8;

  // legal setting ranges and reset values
  localparam logic [15:0] DISP_LO  = 16'h0001;
  localparam logic [15:0] DISP_HI  = 16'h0005;
  localparam logic [15:0] PON_LO   = 16'h0000;
  localparam logic [15:0] PON_HI   = 16'h0008;
  localparam logic [15:0] LOCK_HI  = 16'h0001;
  localparam logic [3:0]  PON_FACT = 4'h8;
  localparam logic [2:0]  DISP_RST = 3'h1;

  // control and status bit positions, error word layout
  localparam int unsigned CTL_LOCAL  = 0;
  localparam int unsigned CTL_REMOTE = 1;
  localparam int unsigned CTL_SAVE   = 2;
  localparam int unsigned STS_REMOTE = 0;
  localparam int unsigned STS_DUAL   = 1;
  localparam int unsigned STS_FIXED  = 2;
  localparam int unsigned STS_PAR    = 3;
  localparam int unsigned STS_CAL    = 4;
  localparam int unsigned STS_DFLT   = 5;
  localparam int unsigned STS_CNT    = 8;
  localparam int unsigned ERR_ID     = 16;

  typedef enum logic [2:0] {
    MSG_NONE     = 3'h0,
    MSG_CMD      = 3'h1,
    MSG_PROT     = 3'h2,
    MSG_CONFLICT = 3'h3,
    MSG_RANGE    = 3'h4,
    MSG_OVF      = 3'h5
  } lds_msg_t;

  // signed error numbers, 16-bit two's complement
  function automatic logic [15:0] lds_msg_code(input lds_msg_t m);
    case (m)
      MSG_CMD:      lds_msg_code = 16'hff9c;
      MSG_PROT:     lds_msg_code = 16'hff35;
      MSG_CONFLICT: lds_msg_code = 16'hff23;
      MSG_RANGE:    lds_msg_code = 16'hff22;
      MSG_OVF:      lds_msg_code = 16'hfea2;
      default:      lds_msg_code = 16'h0000;
    endcase
  endfunction

  typedef enum logic [0:0] {
    ST_INIT = 1'b0,
    ST_RUN  = 1'b1
  } lds_st_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } lds_bus_req_t;

  typedef struct packed {
    logic       go;
    logic       dflt;
    logic [3:0] sel;
  } lds_init_t;

  typedef struct packed {
    logic       wr;
    logic       lockout;
    logic [3:0] pon;
  } lds_nv_t;

  typedef struct packed {
    lds_msg_t [FIFO_DEPTH-1:0] mem;
    logic [3:0]                cnt;
  } lds_fifo_st_t;

  typedef struct packed {
    lds_st_t     st;
    logic        remote;
    logic [2:0]  disp;
    logic        lockout;
    logic [3:0]  pon;
    logic [15:0] freq;
    logic        push;
    lds_msg_t    push_id;
    logic [31:0] rdata;
    logic        nv_wr;
    logic        cal_save;
    lds_init_t   init;
  } lds_state_t;
endpackage
`default_nettype wire

// ---- verilog/lds_range_chk.sv ----
// lds_range_chk: inclusive range test of a 16-bit setting value
// assumes lo is not above hi; purely combinational
`timescale 1ns/1ps
`default_nettype none
module lds_range_chk (
  input  wire logic [15:0] val, // value under test
  input  wire logic [15:0] lo,  // least legal value
  input  wire logic [15:0] hi,  // greatest legal value
  output logic             ok   // value within lo..hi
);
  // both bounds inclusive
  assign ok = (val >= lo) && (val <= hi);
endmodule
`default_nettype wire

// ---- verilog/lds_err_fifo.sv ----
// lds_err_fifo: shifting error queue with an overflow marker in its last slot
// assumes at most one push and one pop per cycle from the handler
`timescale 1ns/1ps
`default_nettype none
module lds_err_fifo (
  input  wire logic              core_clk, // system clock
  input  wire logic              rst_n,    // async reset, active low
  input  wire logic              push,     // store one error
  input  wire lds_pkg::lds_msg_t push_id,  // error to store
  input  wire logic              pop,      // remove head entry
  output lds_pkg::lds_msg_t      head,     // oldest entry, none when empty
  output logic [3:0]             cnt       // entries held
);
  lds_pkg::lds_fifo_st_t s_r;
  lds_pkg::lds_fifo_st_t s_nxt;

  // pop shifts down first, then a push lands behind the survivors
  always_comb
  begin
    s_nxt = s_r;
    if (pop && (s_r.cnt != 4'h0))
    begin
      for (int i = 0; i < lds_pkg::FIFO_DEPTH - 1; i++)
      begin
        s_nxt.mem[i] = s_r.mem[i+1];
      end
      s_nxt.mem[lds_pkg::FIFO_DEPTH-1] = lds_pkg::MSG_NONE;
      s_nxt.cnt = s_r.cnt - 4'h1;
    end
    if (push)
    begin
      if (s_nxt.cnt == lds_pkg::FIFO_FULL)
        s_nxt.mem[lds_pkg::FIFO_DEPTH-1] = lds_pkg::MSG_OVF;
      else
      begin
        s_nxt.mem[s_nxt.cnt[2:0]] = push_id;
        s_nxt.cnt = s_nxt.cnt + 4'h1;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign head = s_r.mem[0]; // empty slots hold none
  assign cnt  = s_r.cnt;

  a_ovf_mark: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    push && !pop && (s_r.cnt == lds_pkg::FIFO_FULL)
    |=> (s_r.mem[lds_pkg::FIFO_DEPTH-1] == lds_pkg::MSG_OVF) && (s_r.cnt == lds_pkg::FIFO_FULL))
    else $error("overflow entry not placed in last slot");

  c_fifo_full: cover property (
    @(posedge core_clk) disable iff (!rst_n)
    push && !pop && (s_r.cnt == lds_pkg::FIFO_FULL));
endmodule
`default_nettype wire

// ---- verilog/lds_handler.sv ----
// lds_handler: limit queries, readout select, error queue and system control
// assumes a register master that never overlaps strobes; straps valid at reset release
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lds_handler #(
  parameter logic [15:0] VLIM    = lds_pkg::VLIM_DFLT, // voltage limit
  parameter logic [15:0] CLIM    = lds_pkg::CLIM_DFLT, // low-range current limit
  parameter logic [15:0] FLIM_LO = lds_pkg::FLO_DFLT,  // lower frequency limit
  parameter logic [15:0] FLIM_HI = lds_pkg::FHI_DFLT   // upper frequency limit
) (
  input  wire logic                  core_clk,     // 10 MHz clock
  input  wire logic                  rst_n,        // async reset, active low
  input  wire lds_pkg::lds_bus_req_t bus_req,      // register request
  output logic [31:0]                bus_rdata,    // read data, cycle after read
  input  wire logic                  par_bus_sel,  // parallel bus in use
  input  wire logic                  ren,          // parallel bus remote enable
  input  wire logic                  cal_mode,     // calibration mode active
  input  wire logic                  pu_lockout,   // stored power-up lockout
  input  wire logic [3:0]            pu_sel,       // stored power-on selector
  input  wire logic                  pu_sel_valid, // selected state data valid
  output logic                       remote,       // remote state, keys locked
  output logic [2:0]                 disp_mode,    // right display selection
  output logic [15:0]                freq_set,     // accepted frequency
  output logic                       cal_save,     // coefficient save pulse
  output lds_pkg::lds_nv_t           nv,           // non-volatile setting write
  output lds_pkg::lds_init_t         init          // power-up load request
);
  localparam logic FIX_F = (FLIM_LO == FLIM_HI);
  localparam logic DUAL  = (VLIM > lds_pkg::DUAL_ABOVE);

  lds_pkg::lds_state_t s_r;
  lds_pkg::lds_state_t s_nxt;
  lds_pkg::lds_msg_t   err_head;
  logic [3:0]          err_cnt;
  logic                err_pop;
  logic                disp_ok;
  logic                pon_ok;
  logic                lock_ok;
  logic                freq_ok;
  logic                hi_zero;
  logic                wr_lim;
  logic [15:0]         vlow;

  // range checks of incoming setting values
  lds_range_chk u_disp_chk (
    .val (bus_req.wdata[15:0]),
    .lo  (lds_pkg::DISP_LO),
    .hi  (lds_pkg::DISP_HI),
    .ok  (disp_ok)
  );

  lds_range_chk u_pon_chk (
    .val (bus_req.wdata[15:0]),
    .lo  (lds_pkg::PON_LO),
    .hi  (lds_pkg::PON_HI),
    .ok  (pon_ok)
  );

  lds_range_chk u_freq_chk (
    .val (bus_req.wdata[15:0]),
    .lo  (FLIM_LO),
    .hi  (FLIM_HI),
    .ok  (freq_ok)
  );

  // error queue
  lds_err_fifo u_err (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .push     (s_r.push),
    .push_id  (s_r.push_id),
    .pop      (err_pop),
    .head     (err_head),
    .cnt      (err_cnt)
  );

  // request decode helpers
  assign hi_zero = (bus_req.wdata[31:16] == 16'h0000);
  assign lock_ok = (bus_req.wdata[15:0] <= lds_pkg::LOCK_HI);
  assign wr_lim  = bus_req.wr && ((bus_req.addr == lds_pkg::OFS_LIM_VOLT)
                 || (bus_req.addr == lds_pkg::OFS_LIM_CURR)
                 || (bus_req.addr == lds_pkg::OFS_LIM_FLO)
                 || (bus_req.addr == lds_pkg::OFS_LIM_FHI));
  assign err_pop = bus_req.rd && (bus_req.addr == lds_pkg::OFS_ERR);
  assign vlow    = DUAL ? {1'b0, VLIM[15:1]} : VLIM;

  // next-state logic: reads, writes, remote state and power-up load
  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.push     = 1'b0;
    s_nxt.push_id  = lds_pkg::MSG_NONE;
    s_nxt.rdata    = 32'h0000_0000;
    s_nxt.nv_wr    = 1'b0;
    s_nxt.cal_save = 1'b0;
    s_nxt.init.go  = 1'b0;
    // read data for the next cycle only
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        lds_pkg::OFS_LIM_VOLT: s_nxt.rdata = {16'h0000, VLIM};
        lds_pkg::OFS_LIM_CURR: s_nxt.rdata = {16'h0000, CLIM};
        lds_pkg::OFS_LIM_FLO:  s_nxt.rdata = {16'h0000, FLIM_LO};
        lds_pkg::OFS_LIM_FHI:  s_nxt.rdata = {16'h0000, FLIM_HI};
        lds_pkg::OFS_DISP:     s_nxt.rdata = {29'h0000_0000, s_r.disp};
        lds_pkg::OFS_ERR:
          s_nxt.rdata = {13'h0000, err_head, lds_pkg::lds_msg_code(err_head)};
        lds_pkg::OFS_LOCK:     s_nxt.rdata = {31'h0000_0000, s_r.lockout};
        lds_pkg::OFS_PON:      s_nxt.rdata = {28'h000_0000, s_r.pon};
        lds_pkg::OFS_FREQ:     s_nxt.rdata = {16'h0000, s_r.freq};
        lds_pkg::OFS_VLOW:     s_nxt.rdata = {16'h0000, vlow};
        lds_pkg::OFS_STAT:
        begin
          s_nxt.rdata[lds_pkg::STS_REMOTE] = s_r.remote;
          s_nxt.rdata[lds_pkg::STS_DUAL]   = DUAL;
          s_nxt.rdata[lds_pkg::STS_FIXED]  = FIX_F;
          s_nxt.rdata[lds_pkg::STS_PAR]    = par_bus_sel;
          s_nxt.rdata[lds_pkg::STS_CAL]    = cal_mode;
          s_nxt.rdata[lds_pkg::STS_DFLT]   = s_r.init.dflt;
          s_nxt.rdata[lds_pkg::STS_CNT+:4] = err_cnt;
        end
        default:               s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // writes
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        lds_pkg::OFS_LIM_VOLT, lds_pkg::OFS_LIM_CURR,
        lds_pkg::OFS_LIM_FLO, lds_pkg::OFS_LIM_FHI:
        begin
          s_nxt.push    = 1'b1;
          s_nxt.push_id = lds_pkg::MSG_PROT;
        end
        lds_pkg::OFS_DISP:
          if (disp_ok && hi_zero)
            s_nxt.disp = bus_req.wdata[2:0];
          else
          begin
            s_nxt.push    = 1'b1;
            s_nxt.push_id = lds_pkg::MSG_RANGE;
          end
        lds_pkg::OFS_LOCK:
          if (lock_ok && hi_zero)
          begin
            s_nxt.lockout = bus_req.wdata[0];
            s_nxt.nv_wr   = 1'b1;
          end
          else
          begin
            s_nxt.push    = 1'b1;
            s_nxt.push_id = lds_pkg::MSG_RANGE;
          end
        lds_pkg::OFS_PON:
          if (pon_ok && hi_zero)
          begin
            s_nxt.pon   = bus_req.wdata[3:0];
            s_nxt.nv_wr = 1'b1;
          end
          else
          begin
            s_nxt.push    = 1'b1;
            s_nxt.push_id = lds_pkg::MSG_RANGE;
          end
        lds_pkg::OFS_FREQ:
          if (FIX_F && (!hi_zero || (bus_req.wdata[15:0] != FLIM_LO)))
          begin
            s_nxt.push    = 1'b1;
            s_nxt.push_id = lds_pkg::MSG_CMD;
          end
          else if (!freq_ok || !hi_zero)
          begin
            s_nxt.push    = 1'b1;
            s_nxt.push_id = lds_pkg::MSG_RANGE;
          end
          else
            s_nxt.freq = bus_req.wdata[15:0];
        lds_pkg::OFS_CTRL:
        begin
          // serial go-local and go-remote, ignored under the parallel bus
          if (!par_bus_sel && bus_req.wdata[lds_pkg::CTL_LOCAL])
            s_nxt.remote = 1'b0;
          if (!par_bus_sel && bus_req.wdata[lds_pkg::CTL_REMOTE])
            s_nxt.remote = 1'b1;
          if (bus_req.wdata[lds_pkg::CTL_SAVE])
          begin
            if (cal_mode)
              s_nxt.cal_save = 1'b1;
            else
            begin
              s_nxt.push    = 1'b1;
              s_nxt.push_id = lds_pkg::MSG_CONFLICT;
            end
          end
        end
        default:
        begin
        end
      endcase
    end
    // parallel bus owns remote state
    if (par_bus_sel)
      s_nxt.remote = ren;
    // one-time power-up load after reset release
    unique case (s_r.st)
      lds_pkg::ST_INIT:
      begin
        s_nxt.st        = lds_pkg::ST_RUN;
        s_nxt.lockout   = pu_lockout;
        s_nxt.pon       = pu_sel;
        s_nxt.remote    = par_bus_sel ? ren : pu_lockout;
        s_nxt.init.go   = 1'b1;
        s_nxt.init.sel  = pu_sel;
        s_nxt.init.dflt = !pu_sel_valid || (pu_sel >= lds_pkg::PON_FACT);
      end
      lds_pkg::ST_RUN:
      begin
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r      <= '0;
      s_r.disp <= lds_pkg::DISP_RST;
      s_r.freq <= FLIM_LO;
    end
    else
      s_r <= s_nxt;
  end

  // outputs straight from the state register
  assign bus_rdata  = s_r.rdata;
  assign remote     = s_r.remote;
  assign disp_mode  = s_r.disp;
  assign freq_set   = s_r.freq;
  assign cal_save   = s_r.cal_save;
  assign init       = s_r.init;
  assign nv         = '{wr: s_r.nv_wr, lockout: s_r.lockout, pon: s_r.pon};

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_lim_refuse: assert property (
    wr_lim |=> s_r.push && (s_r.push_id == lds_pkg::MSG_PROT) ##1 (err_cnt != 4'h0))
    else $error("limit write not refused");

  a_curr_read: assert property (
    bus_req.rd && (bus_req.addr == lds_pkg::OFS_LIM_CURR) |=> bus_rdata == {16'h0000, CLIM})
    else $error("current limit read wrong");

  a_freq_fixed: assert property (
    FIX_F && bus_req.wr && (bus_req.addr == lds_pkg::OFS_FREQ)
    && (bus_req.wdata[15:0] != FLIM_LO)
    |=> s_r.push && (s_r.push_id == lds_pkg::MSG_CMD) && $stable(s_r.freq))
    else $error("fixed frequency violation not flagged");

  a_vlow_half: assert property (
    DUAL && bus_req.rd && (bus_req.addr == lds_pkg::OFS_VLOW)
    |=> bus_rdata[15:0] == {1'b0, VLIM[15:1]})
    else $error("low range maximum not half");

  a_disp_bad: assert property (
    bus_req.wr && (bus_req.addr == lds_pkg::OFS_DISP) && !disp_ok
    |=> $stable(s_r.disp) && s_r.push && (s_r.push_id == lds_pkg::MSG_RANGE))
    else $error("bad readout value accepted");

  a_err_empty: assert property (
    err_pop && (err_cnt == 4'h0) |=> bus_rdata == 32'h0000_0000)
    else $error("empty queue read not zero");

  a_lock_hold: assert property (
    (s_r.st == lds_pkg::ST_RUN) && !par_bus_sel && bus_req.wr
    && (bus_req.addr == lds_pkg::OFS_LOCK)
    |=> $stable(s_r.remote) && (nv.wr == $past(lock_ok && hi_zero)))
    else $error("lockout write moved remote state");

  a_ren_follow: assert property (
    rst_n && par_bus_sel |=> remote == $past(ren))
    else $error("remote does not follow enable line");

  a_go_local: assert property (
    (s_r.st == lds_pkg::ST_RUN) && !par_bus_sel && bus_req.wr
    && (bus_req.addr == lds_pkg::OFS_CTRL) && bus_req.wdata[0] && !bus_req.wdata[1]
    |=> !remote)
    else $error("go-local ignored");

  a_cal_refuse: assert property (
    bus_req.wr && (bus_req.addr == lds_pkg::OFS_CTRL) && bus_req.wdata[2] && !cal_mode
    |=> !cal_save && (s_r.push_id == lds_pkg::MSG_CONFLICT))
    else $error("save accepted outside calibration");

  a_pon_dflt: assert property (
    rst_n && (s_r.st == lds_pkg::ST_INIT) && (!pu_sel_valid || (pu_sel == lds_pkg::PON_FACT))
    |=> init.go && init.dflt ##1 !init.go)
    else $error("factory default load not requested");

  // power-up state, accepted readout value and accepted save
  a_pu_remote: assert property (
    rst_n && (s_r.st == lds_pkg::ST_INIT) && !par_bus_sel
    |=> remote == $past(pu_lockout))
    else $error("power-up remote state wrong");

  a_disp_take: assert property (
    bus_req.wr && (bus_req.addr == lds_pkg::OFS_DISP) && disp_ok && hi_zero
    |=> disp_mode == $past(bus_req.wdata[2:0]))
    else $error("readout value not taken");

  a_cal_pulse: assert property (
    bus_req.wr && (bus_req.addr == lds_pkg::OFS_CTRL) && bus_req.wdata[2] && cal_mode
    |=> cal_save && !s_r.push)
    else $error("save in calibration mode not issued");

  c_err_read: cover property (err_pop && (err_cnt != 4'h0));
  c_go_remote: cover property (!par_bus_sel && bus_req.wr
    && (bus_req.addr == lds_pkg::OFS_CTRL) && bus_req.wdata[1]);
  c_cal_save: cover property (cal_save);
endmodule
`default_nettype wire

// ---- tb/lds_host.sv ----
// lds_host: remote controller model, register master and parallel bus enable
// assumes the handler samples strobes on the rising edge of core_clk
`timescale 1ns/1ps
`default_nettype none
module lds_host (
  input  wire logic             core_clk,  // system clock
  input  wire logic [31:0]      bus_rdata, // read data, cycle after read
  output var lds_pkg::lds_bus_req_t bus_req, // register request
  output var logic              ren        // parallel bus remote enable
);
  // idle bus and local line from time zero
  initial
  begin
    bus_req = '0;
    ren = 1'b0;
  end
  // one write strobe with address and data, then idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
  endtask
  // one read strobe; data taken at the edge that ends its answer cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req <= '0;
    @(posedge core_clk);
    d = bus_rdata;
  endtask
  // remote enable as the bus controller drives it
  task automatic set_ren(input logic v);
    @(posedge core_clk);
    ren <= v;
  endtask
endmodule
`default_nettype wire

// ---- tb/lds_handler_test.sv ----
// lds_handler_test: self-checking bench of the limit, display and system handler
// assumes lds_host as register master; one 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module lds_handler_test;
  localparam logic [15:0] FFIX = 16'h0168; // single fixed frequency
  localparam logic [15:0] VLIM = 16'h010e; // dual range high maximum
  localparam logic [15:0] CLIM = 16'h0064; // low range current
  logic core_clk, rst_n, par_bus_sel, ren, cal_mode, pu_lockout, pu_sel_valid;
  logic remote, cal_save;
  logic [3:0]  pu_sel;
  logic [2:0]  disp_mode;
  logic [15:0] freq_set;
  logic [31:0] bus_rdata;
  lds_pkg::lds_bus_req_t bus_req;
  lds_pkg::lds_nv_t      nv_o;
  lds_pkg::lds_init_t    init_o;
  int n_fail, n_compared, n_save, n_nv, n_init, cyc;
  lds_handler #(.VLIM(VLIM), .CLIM(CLIM), .FLIM_LO(FFIX), .FLIM_HI(FFIX)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .par_bus_sel(par_bus_sel), .ren(ren), .cal_mode(cal_mode), .pu_lockout(pu_lockout),
    .pu_sel(pu_sel), .pu_sel_valid(pu_sel_valid), .remote(remote), .disp_mode(disp_mode),
    .freq_set(freq_set), .cal_save(cal_save), .nv(nv_o), .init(init_o));
  lds_host host (.core_clk(core_clk), .bus_rdata(bus_rdata), .bus_req(bus_req), .ren(ren));
  // clock, save pulse count and hang limit
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cal_save === 1'b1)
      n_save++;
    if (nv_o.wr === 1'b1)
      n_nv++;
    if (init_o.go === 1'b1)
      n_init++;
    if (cyc == 5000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    host.rd(a, d);
    chk(nm, e, d);
  endtask
  task automatic ck_err(input logic [2:0] id, input logic [15:0] c);
    rchk("err", lds_pkg::OFS_ERR, {13'h0, id, c});
  endtask
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // reset with given straps, then power-up state
  task automatic rst(input logic lk, input logic [3:0] sl, input logic v, input logic df);
    int i0;
    @(posedge core_clk);
    i0 = n_init;
    pu_lockout <= lk;
    pu_sel <= sl;
    pu_sel_valid <= v;
    rst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("remote", 32'(lk), 32'(remote));
    chk("dflt", 32'(df), 32'(init_o.dflt));
    chk("sel", 32'(sl), 32'(init_o.sel));
    chk("disp", 32'h1, 32'(disp_mode));
    chk("init_go", 32'(i0 + 1), 32'(n_init));
  endtask
  // limits read back, refused writes queue a protected error
  task automatic t_limits();
    logic [31:0] d;
    rchk("err0", lds_pkg::OFS_ERR, 32'h0);
    rchk("vlim", lds_pkg::OFS_LIM_VOLT, 32'(VLIM));
    rchk("clim", lds_pkg::OFS_LIM_CURR, 32'(CLIM));
    rchk("flo", lds_pkg::OFS_LIM_FLO, 32'(FFIX));
    rchk("fhi", lds_pkg::OFS_LIM_FHI, 32'(FFIX));
    rchk("vlow", lds_pkg::OFS_VLOW, 32'(VLIM >> 1));
    host.rd(lds_pkg::OFS_STAT, d);
    chk("dual_fix", 32'h3, 32'(d[2:1]));
    host.wr(lds_pkg::OFS_LIM_VOLT, 32'h0);
    ck_err(3'h2, 16'hff35);
    rchk("vlim", lds_pkg::OFS_LIM_VOLT, 32'(VLIM));
  endtask
  // every readout code, then both neighbours out of range
  task automatic t_disp();
    for (int v = 1; v <= 5; v++)
    begin
      host.wr(lds_pkg::OFS_DISP, 32'(v));
      rchk("disp_rd", lds_pkg::OFS_DISP, 32'(v));
      chk("disp_mode", 32'(v), 32'(disp_mode));
    end
    host.wr(lds_pkg::OFS_DISP, 32'h6);
    host.wr(lds_pkg::OFS_DISP, 32'h0);
    ck_err(3'h4, 16'hff22);
    ck_err(3'h4, 16'hff22);
    chk("disp_mode", 32'h5, 32'(disp_mode));
  endtask
  // nine errors into eight slots: last becomes overflow
  task automatic t_queue();
    repeat (9) host.wr(lds_pkg::OFS_LIM_CURR, 32'h1);
    settle();
    repeat (7) ck_err(3'h2, 16'hff35);
    ck_err(3'h5, 16'hfea2);
    ck_err(3'h0, 16'h0000);
  endtask
  // fixed frequency: same value taken, any other refused
  task automatic t_freq();
    host.wr(lds_pkg::OFS_FREQ, 32'(FFIX));
    host.wr(lds_pkg::OFS_FREQ, 32'(FFIX + 16'h0001));
    ck_err(3'h1, 16'hff9c);
    ck_err(3'h0, 16'h0000);
    chk("freq", 32'(FFIX), 32'(freq_set));
  endtask
  // lockout writes, serial local and remote, parallel bus enable
  task automatic t_remote();
    host.wr(lds_pkg::OFS_LOCK, 32'h0);
    settle();
    chk("remote", 32'h1, 32'(remote));
    chk("nv_lock", 32'h0, 32'(nv_o.lockout));
    host.wr(lds_pkg::OFS_CTRL, 32'h1);
    settle();
    chk("remote", 32'h0, 32'(remote));
    host.wr(lds_pkg::OFS_LOCK, 32'h1);
    settle();
    chk("remote", 32'h0, 32'(remote));
    host.wr(lds_pkg::OFS_CTRL, 32'h2);
    settle();
    chk("remote", 32'h1, 32'(remote));
    @(posedge core_clk);
    par_bus_sel <= 1'b1;
    settle();
    chk("remote", 32'h0, 32'(remote));
    host.wr(lds_pkg::OFS_CTRL, 32'h2);
    settle();
    chk("remote", 32'h0, 32'(remote));
    host.set_ren(1'b1);
    settle();
    chk("remote", 32'h1, 32'(remote));
    @(posedge core_clk);
    par_bus_sel <= 1'b0;
  endtask
  // selector range 0 to 8, nine refused
  task automatic t_pon();
    int s0;
    s0 = n_nv;
    for (int v = 0; v <= 8; v++)
    begin
      host.wr(lds_pkg::OFS_PON, 32'(v));
      rchk("pon", lds_pkg::OFS_PON, 32'(v));
    end
    host.wr(lds_pkg::OFS_PON, 32'h9);
    ck_err(3'h4, 16'hff22);
    rchk("pon", lds_pkg::OFS_PON, 32'h8);
    chk("nv_wr", 32'(s0 + 9), 32'(n_nv));
  endtask
  // coefficient save only in calibration mode
  task automatic t_cal();
    int s0;
    s0 = n_save;
    host.wr(lds_pkg::OFS_CTRL, 32'h4);
    ck_err(3'h3, 16'hff23);
    chk("save_off", 32'(s0), 32'(n_save));
    cal_mode <= 1'b1;
    host.wr(lds_pkg::OFS_CTRL, 32'h4);
    settle();
    chk("save_on", 32'(s0 + 1), 32'(n_save));
    ck_err(3'h0, 16'h0000);
  endtask
  // main sequence
  initial
  begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    par_bus_sel = 1'b0;
    cal_mode = 1'b0;
    pu_lockout = 1'b0;
    pu_sel = 4'h0;
    pu_sel_valid = 1'b0;
    n_fail = 0;
    n_compared = 0;
    n_save = 0;
    n_nv = 0;
    n_init = 0;
    cyc = 0;
    rst(1'b0, 4'h8, 1'b1, 1'b1);
    rst(1'b1, 4'h3, 1'b0, 1'b1);
    rst(1'b1, 4'h3, 1'b1, 1'b0);
    t_limits();
    t_disp();
    t_queue();
    t_freq();
    t_remote();
    t_pon();
    t_cal();
    wrap_up();
  end
endmodule
`default_nettype wire
